// file: core/external_trigger_detector.sv
// External trigger detector with APB registers and event interrupt.
// Behaviour
// [R01] Evaluate both inputs on every sample strobe; the code skips a strobe that falls in a write-commit cycle.
// [R02] All-zero mode disables input detection.
// [R03] Rising mode triggers on rising level 0.
// [R04] Falling mode triggers on falling level 0.
// [R05] Dual mode triggers on any level 0 crossing.
// [R06] High mode detects while above level 0.
// [R07] Low mode detects while below level 0.
// [R08] Rising re-arm: arm at level 1, fire at 0.
// [R09] Falling re-arm: arm at level 0, fire at 1.
// [R10] Disarmed re-arm ignores crossings until re-armed.
// [R11] Window enter fires on outside-to-inside move.
// [R12] Two-level modes only on main input.
// [R13] Input counts only when OR/AND mask selects.
// [R14] Secondary has one level, range plus/minus 10000.
// [R15] Main has two levels, range plus/minus 10000.
// [R16] Read-only minimum, maximum and step per input.
// [R17] Read-only secondary supported mode bitmask.
// [R18] Software programs levels before relying on detection.
// [R19] Crossing compares current and previous relation.
//
// The APB slave port was decided locally.
module external_trigger_detector
  import ext_trigger_pkg::*;
(
  input wire logic sys_clk, // System and sample clock, 200 MHz.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [31:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error answer.
  input wire logic sample_valid, // One cycle per sample of the rate.
  input wire logic [SAMPLE_W-1:0] main_sample, // Main input, signed mV.
  input wire logic [SAMPLE_W-1:0] secondary_sample, // Secondary, mV.
  output logic main_detect, // Main input detection.
  output logic secondary_detect, // Secondary input detection.
  output logic trigger_or_out, // OR-mask combined trigger.
  output logic trigger_and_out, // AND-mask combined trigger.
  output logic irq // Level interrupt, high while unmasked event set.
);

  // The whole state of the block in one record.
  typedef struct packed {
    logic [31:0] or_mask;
    logic [31:0] and_mask;
    logic [31:0] main_mode;
    logic [31:0] sec_mode;
    logic [31:0] lvl_a;
    logic [31:0] lvl_b;
    logic [31:0] sec_lvl;
    logic [1:0] evt_status;
    logic [1:0] evt_mask;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic main_prev_ok;
    logic main_prev_above_a;
    logic main_prev_above_b;
    logic main_prev_inside;
    logic main_armed;
    logic sec_prev_ok;
    logic sec_prev_above;
    logic main_det;
    logic sec_det;
    logic or_trig;
    logic and_trig;
    logic irq;
  } state_t;

  state_t state_reg; // Registered state.
  state_t state_next; // Next state.

  // Byte address of a register index.
  function automatic logic [31:0] reg_addr(input logic [15:0] idx);
    reg_addr = {14'h0000, idx, 2'h0};
  endfunction

  // Clamp a written level to the programmable range.
  function automatic logic [31:0] clamp_level(input logic [31:0] v);
    if ($signed(v) < $signed(LEVEL_MIN_MV)) begin
      clamp_level = LEVEL_MIN_MV;
    end else if ($signed(v) > $signed(LEVEL_MAX_MV)) begin
      clamp_level = LEVEL_MAX_MV;
    end else begin
      clamp_level = v;
    end
  endfunction

  // Strict greater-than between a sample and a level.
  function automatic logic above(input logic [SAMPLE_W-1:0] s,
                                 input logic [31:0] lvl);
    above = $signed({{(32-SAMPLE_W){s[SAMPLE_W-1]}}, s}) > $signed(lvl);
  endfunction

  // Strict less-than between a sample and a level.
  function automatic logic below(input logic [SAMPLE_W-1:0] s,
                                 input logic [31:0] lvl);
    below = $signed({{(32-SAMPLE_W){s[SAMPLE_W-1]}}, s}) < $signed(lvl);
  endfunction

  // Outputs come straight from the state flip-flops.
  assign prdata = state_reg.rdata;
  assign pready = state_reg.ready;
  assign pslverr = state_reg.slverr;
  assign main_detect = state_reg.main_det;
  assign secondary_detect = state_reg.sec_det;
  assign trigger_or_out = state_reg.or_trig;
  assign trigger_and_out = state_reg.and_trig;
  assign irq = state_reg.irq;

  // Next-state logic: bus slave, detectors, masks and interrupt.
  always_comb begin
    logic m_above_a; // Main sample above level 0.
    logic m_above_b; // Main sample above level 1.
    logic m_inside; // Main sample inside window.
    logic s_above; // Secondary sample above its level.
    logic m_evt; // Main detection this sample.
    logic s_evt; // Secondary detection this sample.
    logic m_edge_mode; // Main mode produces pulses.
    logic s_edge_mode; // Secondary mode produces pulses.
    logic access; // APB access phase, answer due.
    logic wr_done; // Write commits this edge.
    logic [1:0] evt_set; // Event bits set this cycle.
    logic [1:0] evt_clr; // Event bits cleared by software.
    logic hit; // Address is mapped.
    logic ro; // Address is read-only.
    logic [31:0] rd; // Read data mux.
    logic and_any; // AND mask selects any input.
    logic and_ok; // All AND-selected inputs detect.
    m_above_a = 1'b0;
    m_above_b = 1'b0;
    m_inside = 1'b0;
    s_above = 1'b0;
    m_evt = 1'b0;
    s_evt = 1'b0;
    m_edge_mode = 1'b0;
    s_edge_mode = 1'b0;
    access = 1'b0;
    wr_done = 1'b0;
    and_any = 1'b0;
    and_ok = 1'b0;
    evt_set = 2'h0;
    evt_clr = 2'h0;
    hit = 1'b1;
    ro = 1'b0;
    rd = 32'h00000000;
    state_next = state_reg;

    // Read decode of every mapped register.
    case (paddr)
      reg_addr(IDX_TRIGGER_OR_MASK): rd = state_reg.or_mask;
      reg_addr(IDX_TRIGGER_AND_MASK): rd = state_reg.and_mask;
      // [R17] Secondary mode caps.
      reg_addr(IDX_SECONDARY_INPUT_MODE_CAPS): begin
        rd = SECONDARY_MODE_CAPS;
        ro = 1'b1;
      end
      reg_addr(IDX_MAIN_INPUT_MODE): rd = state_reg.main_mode;
      reg_addr(IDX_SECONDARY_INPUT_MODE): rd = state_reg.sec_mode;
      reg_addr(IDX_MAIN_INPUT_LEVEL_A): rd = state_reg.lvl_a;
      reg_addr(IDX_SECONDARY_INPUT_LEVEL): rd = state_reg.sec_lvl;
      reg_addr(IDX_MAIN_INPUT_LEVEL_B): rd = state_reg.lvl_b;
      // [R16] Level capability values.
      reg_addr(IDX_MAIN_LEVEL_MINIMUM),
      reg_addr(IDX_SECONDARY_LEVEL_MINIMUM): begin
        rd = LEVEL_MIN_MV;
        ro = 1'b1;
      end
      reg_addr(IDX_MAIN_LEVEL_MAXIMUM),
      reg_addr(IDX_SECONDARY_LEVEL_MAXIMUM): begin
        rd = LEVEL_MAX_MV;
        ro = 1'b1;
      end
      reg_addr(IDX_MAIN_LEVEL_STEP),
      reg_addr(IDX_SECONDARY_LEVEL_STEP): begin
        rd = LEVEL_STEP_MV;
        ro = 1'b1;
      end
      reg_addr(IDX_EVENT_STATUS): rd = {30'h00000000, state_reg.evt_status};
      reg_addr(IDX_EVENT_MASK): rd = {30'h00000000, state_reg.evt_mask};
      default: begin
        hit = 1'b0;
      end
    endcase

    // The slave answers in the second access cycle; ready is a flop.
    access = psel && penable && !state_reg.ready;
    wr_done = psel && penable && state_reg.ready && pwrite &&
              !state_reg.slverr;
    state_next.ready = access;
    state_next.slverr = access && (!hit || (pwrite && ro));
    if (access) begin
      state_next.rdata = pwrite ? 32'h00000000 : rd;
    end

    // Register writes take effect at the edge where ready is sampled.
    if (wr_done) begin
      case (paddr)
        reg_addr(IDX_TRIGGER_OR_MASK): state_next.or_mask = pwdata;
        reg_addr(IDX_TRIGGER_AND_MASK): state_next.and_mask = pwdata;
        reg_addr(IDX_MAIN_INPUT_MODE): begin
          state_next.main_mode = pwdata;
          state_next.main_prev_ok = 1'b0;
          state_next.main_armed = 1'b0;
        end
        reg_addr(IDX_SECONDARY_INPUT_MODE): begin
          state_next.sec_mode = pwdata;
          state_next.sec_prev_ok = 1'b0;
        end
        // [R15] Two main levels, clamped.
        reg_addr(IDX_MAIN_INPUT_LEVEL_A): state_next.lvl_a =
          clamp_level(pwdata);
        reg_addr(IDX_MAIN_INPUT_LEVEL_B): state_next.lvl_b =
          clamp_level(pwdata);
        // [R14] One secondary level, clamped.
        reg_addr(IDX_SECONDARY_INPUT_LEVEL): state_next.sec_lvl =
          clamp_level(pwdata);
        reg_addr(IDX_EVENT_STATUS): evt_clr = pwdata[1:0];
        reg_addr(IDX_EVENT_MASK): state_next.evt_mask = pwdata[1:0];
        default: begin
          evt_clr = 2'h0;
        end
      endcase
    end

    // Sample relations against the programmed thresholds.
    m_above_a = above(main_sample, state_reg.lvl_a);
    m_above_b = above(main_sample, state_reg.lvl_b);
    m_inside = !m_above_a && !below(main_sample, state_reg.lvl_b);
    s_above = above(secondary_sample, state_reg.sec_lvl);

    // [R01] Evaluate each sample, except one in a write-commit cycle.
    if (sample_valid && !wr_done) begin
      // Main input detector, every mode.
      case (state_reg.main_mode)
        // [R03] Rising edge.
        // [R19] Previous-sample comparison.
        RISING_CROSSING_MODE: begin
          m_edge_mode = 1'b1;
          m_evt = state_reg.main_prev_ok && !state_reg.main_prev_above_a &&
                  m_above_a;
        end
        // [R04] Falling edge.
        FALLING_CROSSING_MODE: begin
          m_edge_mode = 1'b1;
          m_evt = state_reg.main_prev_ok && state_reg.main_prev_above_a &&
                  !m_above_a;
        end
        // [R05] Any crossing.
        ANY_CROSSING_MODE: begin
          m_edge_mode = 1'b1;
          m_evt = state_reg.main_prev_ok &&
                  (state_reg.main_prev_above_a != m_above_a);
        end
        // [R06] Above level.
        ABOVE_LEVEL_MODE: m_evt = m_above_a;
        // [R07] Below level.
        BELOW_LEVEL_MODE: m_evt = below(main_sample, state_reg.lvl_a);
        // [R11] Window entry.
        WINDOW_ENTRY_MODE: begin
          m_edge_mode = 1'b1;
          m_evt = state_reg.main_prev_ok && !state_reg.main_prev_inside &&
                  m_inside;
        end
        // [R08] Rising re-arm.
        RISING_REARM_MODE: begin
          m_edge_mode = 1'b1;
          // [R10] Fire only while armed.
          m_evt = state_reg.main_armed && state_reg.main_prev_ok &&
                  !state_reg.main_prev_above_a && m_above_a;
          if (m_evt) begin
            state_next.main_armed = 1'b0;
          end else if (state_reg.main_prev_ok &&
                       !state_reg.main_prev_above_b && m_above_b) begin
            state_next.main_armed = 1'b1;
          end
        end
        // [R09] Falling re-arm.
        FALLING_REARM_MODE: begin
          m_edge_mode = 1'b1;
          // [R10] Fire only while armed.
          m_evt = state_reg.main_armed && state_reg.main_prev_ok &&
                  state_reg.main_prev_above_b && !m_above_b;
          if (m_evt) begin
            state_next.main_armed = 1'b0;
          end else if (state_reg.main_prev_ok &&
                       state_reg.main_prev_above_a && !m_above_a) begin
            state_next.main_armed = 1'b1;
          end
        end
        // [R02] Disabled or unknown mode.
        default: begin
          m_evt = 1'b0;
        end
      endcase

      // [R12] Secondary has single-level modes only.
      case (state_reg.sec_mode)
        RISING_CROSSING_MODE: begin
          s_edge_mode = 1'b1;
          s_evt = state_reg.sec_prev_ok && !state_reg.sec_prev_above &&
                  s_above;
        end
        FALLING_CROSSING_MODE: begin
          s_edge_mode = 1'b1;
          s_evt = state_reg.sec_prev_ok && state_reg.sec_prev_above &&
                  !s_above;
        end
        ANY_CROSSING_MODE: begin
          s_edge_mode = 1'b1;
          s_evt = state_reg.sec_prev_ok &&
                  (state_reg.sec_prev_above != s_above);
        end
        ABOVE_LEVEL_MODE: s_evt = s_above;
        BELOW_LEVEL_MODE: s_evt = below(secondary_sample, state_reg.sec_lvl);
        // [R02] Disabled or unsupported mode.
        default: begin
          s_evt = 1'b0;
        end
      endcase

      // Remember this sample's relations for the next crossing test.
      state_next.main_prev_ok = 1'b1;
      state_next.main_prev_above_a = m_above_a;
      state_next.main_prev_above_b = m_above_b;
      state_next.main_prev_inside = m_inside;
      state_next.sec_prev_ok = 1'b1;
      state_next.sec_prev_above = s_above;
      state_next.main_det = m_evt;
      state_next.sec_det = s_evt;
    end else if (wr_done) begin
      // A register write drops the outputs so stale levels do not linger.
      state_next.main_det = 1'b0;
      state_next.sec_det = 1'b0;
    end else begin
      // Edge detections are one-cycle pulses; level modes hold.
      if (state_reg.main_mode != ABOVE_LEVEL_MODE &&
          state_reg.main_mode != BELOW_LEVEL_MODE) begin
        state_next.main_det = 1'b0;
      end
      if (state_reg.sec_mode != ABOVE_LEVEL_MODE &&
          state_reg.sec_mode != BELOW_LEVEL_MODE) begin
        state_next.sec_det = 1'b0;
      end
    end

    // [R13] Mask combination.
    state_next.or_trig =
      (state_reg.or_mask[MAIN_INPUT_MASK_BIT] && state_next.main_det) ||
      (state_reg.or_mask[SECONDARY_INPUT_MASK_BIT] && state_next.sec_det);
    and_any = state_reg.and_mask[MAIN_INPUT_MASK_BIT] ||
              state_reg.and_mask[SECONDARY_INPUT_MASK_BIT];
    and_ok =
      (!state_reg.and_mask[MAIN_INPUT_MASK_BIT] || state_next.main_det) &&
      (!state_reg.and_mask[SECONDARY_INPUT_MASK_BIT] || state_next.sec_det);
    state_next.and_trig = and_any && and_ok;

    // Sticky events; a clear is a write cycle, whose sample is not evaluated, so no event is set then.
    evt_set[EVT_MAIN] = m_evt && !state_reg.main_det;
    evt_set[EVT_SECONDARY] = s_evt && !state_reg.sec_det;
    if (m_edge_mode) begin
      evt_set[EVT_MAIN] = m_evt;
    end
    if (s_edge_mode) begin
      evt_set[EVT_SECONDARY] = s_evt;
    end
    state_next.evt_status = (state_reg.evt_status & ~evt_clr) | evt_set;
    state_next.irq = |(state_next.evt_status & state_next.evt_mask);

    // Reset gives every field a defined value.
    if (srst) begin
      state_next = '0;
      state_next.or_mask = MASK_RESET;
      state_next.and_mask = MASK_RESET;
      state_next.main_mode = MODE_RESET;
      state_next.sec_mode = MODE_RESET;
      state_next.lvl_a = LEVEL_RESET;
      state_next.lvl_b = LEVEL_RESET;
      state_next.sec_lvl = LEVEL_RESET;
      state_next.evt_status = EVENT_RESET;
      state_next.evt_mask = EVENT_RESET;
    end
  end

  // Register the whole state on every edge.
  always_ff @(posedge sys_clk) begin
    state_reg <= state_next;
  end

endmodule

// file: core/ext_trigger_pkg.sv
// Constants and register map shared by the external trigger detector.
package ext_trigger_pkg;

  // Register indices; the byte address of each is four times its index.
  localparam logic [15:0] IDX_TRIGGER_OR_MASK = 16'h9DDA;
  localparam logic [15:0] IDX_TRIGGER_AND_MASK = 16'h9DEE;
  localparam logic [15:0] IDX_SECONDARY_INPUT_MODE_CAPS = 16'h9E35;
  localparam logic [15:0] IDX_MAIN_INPUT_MODE = 16'h9E3E;
  localparam logic [15:0] IDX_SECONDARY_INPUT_MODE = 16'h9E3F;
  localparam logic [15:0] IDX_MAIN_INPUT_LEVEL_A = 16'hA550;
  localparam logic [15:0] IDX_SECONDARY_INPUT_LEVEL = 16'hA551;
  localparam logic [15:0] IDX_MAIN_INPUT_LEVEL_B = 16'hA55A;
  localparam logic [15:0] IDX_MAIN_LEVEL_MINIMUM = 16'hA564;
  localparam logic [15:0] IDX_MAIN_LEVEL_MAXIMUM = 16'hA565;
  localparam logic [15:0] IDX_MAIN_LEVEL_STEP = 16'hA566;
  localparam logic [15:0] IDX_SECONDARY_LEVEL_MINIMUM = 16'hA569;
  localparam logic [15:0] IDX_SECONDARY_LEVEL_MAXIMUM = 16'hA56A;
  localparam logic [15:0] IDX_SECONDARY_LEVEL_STEP = 16'hA56B;
  localparam logic [15:0] IDX_EVENT_STATUS = 16'hB000;
  localparam logic [15:0] IDX_EVENT_MASK = 16'hB001;

  // Trigger mode encodings.
  localparam logic [31:0] DETECT_DISABLED = 32'h00000000;
  localparam logic [31:0] RISING_CROSSING_MODE = 32'h00000001;
  localparam logic [31:0] FALLING_CROSSING_MODE = 32'h00000002;
  localparam logic [31:0] ANY_CROSSING_MODE = 32'h00000004;
  localparam logic [31:0] ABOVE_LEVEL_MODE = 32'h00000008;
  localparam logic [31:0] BELOW_LEVEL_MODE = 32'h00000010;
  localparam logic [31:0] WINDOW_ENTRY_MODE = 32'h00000020;
  localparam logic [31:0] HYSTERESIS_ARM_FLAG = 32'h01000000;
  localparam logic [31:0] RISING_REARM_MODE = 32'h01000001;
  localparam logic [31:0] FALLING_REARM_MODE = 32'h01000002;

  // Modes the secondary input supports, one bit per mode.
  localparam logic [31:0] SECONDARY_MODE_CAPS = 32'h0000001F;

  // Trigger mask bit positions.
  localparam int MAIN_INPUT_MASK_BIT = 1;
  localparam int SECONDARY_INPUT_MASK_BIT = 2;

  // Threshold range and step in mV.
  localparam logic [31:0] LEVEL_MIN_MV = 32'hFFFFD8F0;
  localparam logic [31:0] LEVEL_MAX_MV = 32'h00002710;
  localparam logic [31:0] LEVEL_STEP_MV = 32'h00000001;

  // Reset values.
  localparam logic [31:0] MASK_RESET = 32'h00000000;
  localparam logic [31:0] MODE_RESET = 32'h00000000;
  localparam logic [31:0] LEVEL_RESET = 32'h00000000;
  localparam logic [1:0] EVENT_RESET = 2'h0;

  // Event status bits.
  localparam int EVT_MAIN = 0;
  localparam int EVT_SECONDARY = 1;

  // Sample width of each trigger input, signed mV.
  localparam int SAMPLE_W = 16;

endpackage

// file: verif/trig_checker.sv
// Port-level assertions for the external trigger detector.
module trig_checker
  import ext_trigger_pkg::*;
(
  input wire logic sys_clk, // Sample clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [31:0] paddr, // APB byte address.
  input wire logic [31:0] prdata, // APB read data.
  input wire logic pready, // APB ready.
  input wire logic pslverr, // APB error answer.
  input wire logic sample_valid, // Sample strobe.
  input wire logic main_detect, // Main detection.
  input wire logic secondary_detect, // Secondary detection.
  input wire logic trigger_or_out, // OR trigger.
  input wire logic trigger_and_out, // AND trigger.
  input wire logic irq // Level interrupt.
);
  timeunit 1ns;
  timeprecision 100ps;
  // Byte addresses of the read-only places watched below.
  localparam logic [31:0] CAPS_ADDR =
    {14'h0, IDX_SECONDARY_INPUT_MODE_CAPS, 2'h0};
  localparam logic [31:0] MIN_ADDR = {14'h0, IDX_MAIN_LEVEL_MINIMUM, 2'h0};
  logic any_det; // Either input detects.
  logic wr_done; // A write completes this cycle.
  // Helper terms keep the properties short.
  assign any_det = main_detect | secondary_detect;
  assign wr_done = pready & pwrite;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  chk_ready_wait: assert property (
    (psel && penable && !$past(penable)) |-> !pready ##1 pready)
    else $error("pready not after one wait cycle");
  chk_ready_pulse: assert property (
    pready |=> !pready) else $error("pready held longer than a cycle");
  chk_main_sampled: assert property (
    $rose(main_detect) |-> $past(sample_valid))
    else $error("main detect rose without a sample");
  chk_sec_sampled: assert property (
    $rose(secondary_detect) |-> $past(sample_valid))
    else $error("secondary detect rose without a sample");
  chk_or_source: assert property (
    trigger_or_out |-> any_det) else $error("or trigger without detect");
  chk_and_source: assert property (
    trigger_and_out |-> any_det) else $error("and trigger without detect");
  chk_ro_refused: assert property (
    (wr_done && paddr == MIN_ADDR) |-> pslverr)
    else $error("write to read-only minimum accepted");
  chk_caps_value: assert property (
    (pready && !pwrite && paddr == CAPS_ADDR) |->
    (prdata == SECONDARY_MODE_CAPS && !pslverr))
    else $error("secondary mode caps read wrong");
  chk_min_value: assert property (
    (pready && !pwrite && paddr == MIN_ADDR) |-> prdata == LEVEL_MIN_MV)
    else $error("main minimum read wrong");
  chk_irq_cause: assert property (
    $rose(irq) |-> (any_det || $past(wr_done)))
    else $error("irq rose without event or write");
  cover property ($rose(main_detect));
  cover property ($rose(secondary_detect));
  cover property (trigger_and_out);
  cover property ($rose(irq));
endmodule

bind external_trigger_detector trig_checker chk_i (
  .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sample_valid(sample_valid),
  .main_detect(main_detect), .secondary_detect(secondary_detect),
  .trigger_or_out(trigger_or_out), .trigger_and_out(trigger_and_out),
  .irq(irq)
);

// file: verif/trig_source.sv
// Behavioural analog trigger source handing samples at a chosen rate.
module trig_source
  import ext_trigger_pkg::*;
(
  input wire logic sys_clk, // Sample clock.
  output logic sample_valid, // High on cycles that carry a sample.
  output logic [SAMPLE_W-1:0] main_sample, // Main input level, mV.
  output logic [SAMPLE_W-1:0] secondary_sample // Secondary level, mV.
);
  timeunit 1ns;
  timeprecision 100ps;
  int gap = 0; // Idle cycles before a sample; models a slower rate.
  // Lines start quiet so the design sees known values from time zero.
  initial begin
    sample_valid = 1'b0;
    main_sample = '0;
    secondary_sample = '0;
  end
  // one sample per strobe
  // Off-strobe cycles carry the inverse, so a stale capture never matches.
  task automatic put(input logic [SAMPLE_W-1:0] m,
                     input logic [SAMPLE_W-1:0] s);
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    sample_valid <= 1'b1;
    main_sample <= m;
    secondary_sample <= s;
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    main_sample <= ~m;
    secondary_sample <= ~s;
  endtask
endmodule

// file: verif/tb_external_trigger_detector.sv
// Self-checking bench for the external trigger detector.
module tb_external_trigger_detector;
  import ext_trigger_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, srst, psel, penable, pwrite, pready, pslverr, irq;
  logic [31:0] paddr, pwdata, prdata;
  logic sample_valid, main_detect, secondary_detect;
  logic trigger_or_out, trigger_and_out;
  logic [SAMPLE_W-1:0] main_sample, secondary_sample;
  int err_count = 0; // Mismatches seen.
  int comparisons = 0; // Comparisons made.
  int cycles = 0; // Clock cycles since start.
  int k;
  // Sample pattern: 0, +200, 0, -200, 0, +200, 0, +200 mV.
  logic [15:0] pat [0:7] = '{16'h0000, 16'h00C8, 16'h0000, 16'hFF38,
                             16'h0000, 16'h00C8, 16'h0000, 16'h00C8};
  // Read-only places, then two writable registers, and their values after reset.
  logic [15:0] ro_idx [0:8] = '{IDX_SECONDARY_INPUT_MODE_CAPS,
    IDX_MAIN_LEVEL_MINIMUM, IDX_MAIN_LEVEL_MAXIMUM, IDX_MAIN_LEVEL_STEP,
    IDX_SECONDARY_LEVEL_MINIMUM, IDX_SECONDARY_LEVEL_MAXIMUM,
    IDX_SECONDARY_LEVEL_STEP, IDX_MAIN_INPUT_MODE, IDX_TRIGGER_OR_MASK};
  logic [31:0] ro_val [0:8] = '{SECONDARY_MODE_CAPS, LEVEL_MIN_MV,
    LEVEL_MAX_MV, LEVEL_STEP_MV, LEVEL_MIN_MV, LEVEL_MAX_MV,
    LEVEL_STEP_MV, MODE_RESET, MASK_RESET};
  // Mode runs: input, mode, expected detect per sample, skip first sample check.
  // With level 0 at +100 and level 1 at -100 mV; last row runs slowly.
  logic t_sec [0:13] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1};
  logic [31:0] t_mode [0:13] = '{RISING_CROSSING_MODE,
    FALLING_CROSSING_MODE, ANY_CROSSING_MODE, ABOVE_LEVEL_MODE,
    BELOW_LEVEL_MODE, WINDOW_ENTRY_MODE, RISING_REARM_MODE,
    FALLING_REARM_MODE, DETECT_DISABLED, RISING_CROSSING_MODE,
    ANY_CROSSING_MODE, BELOW_LEVEL_MODE, RISING_REARM_MODE,
    FALLING_CROSSING_MODE};
  logic [7:0] t_exp [0:13] = '{8'hA2, 8'h44, 8'hE6, 8'hA2, 8'h5D, 8'h54,
    8'h20, 8'h08, 8'h00, 8'hA2, 8'hE6, 8'h5D, 8'h00, 8'h44};
  logic t_ign [0:13] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};

  external_trigger_detector uut (.sys_clk(sys_clk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .main_sample(main_sample),
    .secondary_sample(secondary_sample), .main_detect(main_detect),
    .secondary_detect(secondary_detect), .trigger_or_out(trigger_or_out),
    .trigger_and_out(trigger_and_out), .irq(irq));
  trig_source src (.sys_clk(sys_clk), .sample_valid(sample_valid),
    .main_sample(main_sample), .secondary_sample(secondary_sample));

  // 200 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Cuts a hang short; the whole run needs well under this.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; reads compare data unless an error is expected.
  task automatic acc(input logic w, input logic [15:0] idx,
                     input logic [31:0] d, input logic e);
    logic [31:0] rd;
    logic er;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {14'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pslverr", {31'h0, e}, {31'h0, er});
    if (!w && !e) chk("prdata", d, rd);
  endtask

  // Programs one input, plays the pattern and checks detect and trigger outputs.
  task automatic run(input logic sec, input logic [31:0] mode,
                     input logic [7:0] exp, input logic ign);
    int j;
    acc(1, sec ? IDX_SECONDARY_INPUT_MODE : IDX_MAIN_INPUT_MODE, mode, 0);
    acc(1, sec ? IDX_MAIN_INPUT_MODE : IDX_SECONDARY_INPUT_MODE,
        DETECT_DISABLED, 0);
    for (j = 0; j < 8; j++) begin
      if (sec) src.put(16'h0000, pat[j]);
      else src.put(pat[j], 16'h0000);
      #1;
      if (!(ign && j == 0)) begin
        chk("detect", {31'h0, exp[j]},
            {31'h0, sec ? secondary_detect : main_detect});
        chk("or_out", {31'h0, exp[j] & ~sec}, {31'h0, trigger_or_out});
        chk("and_out", {31'h0, exp[j] & sec}, {31'h0, trigger_and_out});
      end
      chk("idle_detect", 32'h0,
          {31'h0, sec ? main_detect : secondary_detect});
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence: registers, masks, every mode, then the interrupt.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    srst = 1'b1;
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    for (k = 0; k < 9; k++) acc(0, ro_idx[k], ro_val[k], 0);
    acc(1, IDX_MAIN_LEVEL_MINIMUM, 32'h00000005, 1);
    acc(0, IDX_MAIN_LEVEL_MINIMUM, LEVEL_MIN_MV, 0);
    acc(0, 16'h0000, 32'h0, 1);
    acc(1, IDX_MAIN_INPUT_LEVEL_A, 32'h00004E20, 0);
    acc(0, IDX_MAIN_INPUT_LEVEL_A, LEVEL_MAX_MV, 0);
    acc(1, IDX_MAIN_INPUT_LEVEL_B, 32'hFFFFD8F0, 0);
    acc(0, IDX_MAIN_INPUT_LEVEL_B, LEVEL_MIN_MV, 0);
    acc(1, IDX_SECONDARY_INPUT_LEVEL, 32'hFFFFB1E0, 0);
    acc(0, IDX_SECONDARY_INPUT_LEVEL, LEVEL_MIN_MV, 0);
    acc(1, IDX_MAIN_INPUT_LEVEL_A, 32'h00000064, 0);
    acc(1, IDX_MAIN_INPUT_LEVEL_B, 32'hFFFFFF9C, 0);
    acc(1, IDX_SECONDARY_INPUT_LEVEL, 32'h00000064, 0);
    acc(1, IDX_TRIGGER_OR_MASK, 32'h00000002, 0);
    acc(1, IDX_TRIGGER_AND_MASK, 32'h00000004, 0);
    for (k = 0; k < 14; k++) begin
      src.gap = (k == 13) ? 3 : 0;
      run(t_sec[k], t_mode[k], t_exp[k], t_ign[k]);
    end
    src.gap = 0;
    acc(1, IDX_EVENT_STATUS, 32'h00000003, 0);
    acc(1, IDX_EVENT_MASK, 32'h00000000, 0);
    run(0, RISING_CROSSING_MODE, 8'hA2, 0);
    chk("irq_masked", 32'h0, {31'h0, irq});
    acc(0, IDX_EVENT_STATUS, 32'h00000001, 0);
    acc(1, IDX_EVENT_MASK, 32'h00000001, 0);
    #1;
    chk("irq_set", 32'h1, {31'h0, irq});
    acc(1, IDX_EVENT_STATUS, 32'h00000001, 0);
    #1;
    chk("irq_clear", 32'h0, {31'h0, irq});
    acc(0, IDX_EVENT_STATUS, 32'h00000000, 0);
    stop_test();
  end
endmodule
